// ==== verilog/adcarb_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the converter arbiter
// Assumes: Included by bare name from every file that needs it
// Notes:   Definitions only
`ifndef ADCARB_DEFS_SVH
`define ADCARB_DEFS_SVH

// Slot configuration word fields
`define ADCARB_WIN_LSB        0
`define ADCARB_WIN_MSB        8
`define ADCARB_CHAN_LSB       15
`define ADCARB_CHAN_MSB       18
`define ADCARB_TSEL_LSB       20
`define ADCARB_TSEL_MSB       24

// Converter control one fields
`define ADCARB_LATE_PULSE_BIT 2
`define ADCARB_POWER_UP_BIT   7

// Interrupt pair select fields
`define ADCARB_SEL1_LSB       0
`define ADCARB_SEL1_MSB       3
`define ADCARB_EN1_BIT        5
`define ADCARB_CONT1_BIT      6
`define ADCARB_SEL2_LSB       8
`define ADCARB_SEL2_MSB       11
`define ADCARB_EN2_BIT        13
`define ADCARB_CONT2_BIT      14

// Trigger select code range
`define ADCARB_TSEL_FIRST     5'h05
`define ADCARB_TSEL_LAST      5'h1C

// Slot irq trigger field codes
`define ADCARB_ITRIG_NONE     2'h0
`define ADCARB_ITRIG_LINE1    2'h1
`define ADCARB_ITRIG_LINE2    2'h2

// Conversion length in half converter clocks
`define ADCARB_SE_HALF        10'h015
`define ADCARB_DIFF_HALF      10'h03B

// Reset values
`define ADCARB_PTR_RST        4'hF
`endif

// ==== verilog/adcarb_pkg.sv ====
// Purpose: Types shared by both ends of the converter arbiter link
// Assumes: Counts are set here; field positions stay in adcarb_defs.svh
// Notes:   Sixteen slots, twenty-four start triggers, four irq lines
package adcarb_pkg;
    localparam int NSLOT = 16;
    localparam int NTRIG = 24;
    localparam int NIRQ  = 4;

    typedef logic [31:0] adcarb_cfg_t;
    typedef logic [15:0] adcarb_word_t;
    typedef logic [3:0]  adcarb_idx_t;

    typedef enum logic [1:0] {
        ADCARB_IDLE,
        ADCARB_SAMPLE,
        ADCARB_CONVERT
    } adcarb_state_e;
endpackage : adcarb_pkg

// ==== verilog/adcarb_if.sv ====
// Purpose: Link between start-trigger and interrupt logic and the converter arbiter
// Assumes: Both ends run on the same system clock
// Notes:   Analog inputs are carried as digital sample words
`timescale 1ns/10ps
interface adcarb_if;
    import adcarb_pkg::*;
    logic [NTRIG-1:0]          pwm_trigger_input;  // One-cycle start triggers
    adcarb_word_t [NSLOT-1:0]  analog_input;       // Input sample words
    logic [NIRQ-1:0]           irq_line;           // One-cycle irq pulses

    modport device (
        input  pwm_trigger_input,
        input  analog_input,
        output irq_line
    );
    modport host (
        output pwm_trigger_input,
        output analog_input,
        input  irq_line
    );
endinterface : adcarb_if

// ==== verilog/adcarb_device.sv ====
// Summary of operation
// - Sixteen slots with window, channel, trigger.
// - Window lasts at least one system clock.
// - Window+1 clocks, then 10.5/29.5 converter clocks.
// - Single-ended code n selects input n.
// - Differential ignores channel code bit zero.
// - Codes 05h-1Ch map triggers; others flagged.
// - Pending set by trigger, cleared at finish.
// - Extra triggers stay pending, never abort.
// - Pointer holds last slot, resets to 15.
// - Grant first pending after pointer, wrapping.
// - Window and channel from granted slot.
// - Single-ended 12-bit, differential 16-bit results.
// - Finish gives one-clock pulse on each enabled line selecting the slot.
// - Software sets late pulse bit two.
// - Interrupt pulse coincides with result latch.
// - Four irq outputs; continuous bit kept set.
// - Enable bits 5 and 13 gate interrupts.
// - Source select bits 3:0 and 11:8.
// - Two-bit field: none, line 1, line 2.
// - Nonzero field replaces trigger select source.
// - Result stored in granted slot's register.
// - Divider code gives half-step clock ratio.
//
// Purpose: Slot arbiter, conversion sequencer and interrupt logic of the converter
// Assumes: Configuration words are held stable by software; link is on i_clk
// Notes:   Converter clock is modelled as a cycle count, no second domain
`timescale 1ns/10ps
`include "adcarb_defs.svh"
module adcarb_device (
    input  wire logic                           i_clk,            // System clock 200 MHz
    input  wire logic                           i_rstn,           // Async reset, active low
    adcarb_if.device                            link,             // Triggers, inputs, irq lines
    input  wire adcarb_pkg::adcarb_cfg_t        i_slot_config [16], // Slot configuration words
    input  wire adcarb_pkg::adcarb_word_t       i_ctl_one,        // Converter control one
    input  wire adcarb_pkg::adcarb_word_t       i_irq_pair_sel [2], // Interrupt pair select words
    input  wire adcarb_pkg::adcarb_word_t       i_irq_trig_low,   // Slot irq trigger, slots 0-7
    input  wire adcarb_pkg::adcarb_word_t       i_irq_trig_high,  // Slot irq trigger, slots 8-15
    input  wire logic                           i_input_mode_bit, // 1 = differential
    input  wire logic [3:0]                     i_prescale,       // Converter clock divider code
    output logic                                o_converter_busy, // Conversion in progress
    output adcarb_pkg::adcarb_idx_t             o_busy_slot_index, // Slot being converted
    output adcarb_pkg::adcarb_idx_t             o_last_served_pointer, // Last converted slot
    output logic [15:0]                         o_pending,        // Pending slot flags
    output logic                                o_config_error,   // Invalid trigger setting seen
    output adcarb_pkg::adcarb_word_t            o_slot_result [16] // Result per slot
);
    import adcarb_pkg::*;

    typedef struct packed {
        adcarb_state_e                st;
        logic [NSLOT-1:0]             pend;
        adcarb_idx_t                  ptr;
        adcarb_idx_t                  slot;
        logic [9:0]                   cnt;
        logic                         diff;
        logic [4:0]                   half;
        adcarb_word_t                 sample;
        adcarb_word_t [NSLOT-1:0]     res;
        logic [NIRQ-1:0]              irq;
        logic                         err;
        logic                         busy;
    } adcarb_state_s;

    adcarb_state_s r_r;
    adcarb_state_s r_nxt;

    logic [NSLOT-1:0] slot_set;
    logic [NSLOT-1:0] slot_bad;
    logic [31:0]      itrig_all;
    logic [NIRQ-1:0]  irq_fire;
    logic             grant_ok;
    adcarb_idx_t      grant_idx;
    logic             finish;

    // Per-slot irq trigger fields, slot 15 in the top bits
    assign itrig_all = {i_irq_trig_high, i_irq_trig_low};

    // Per-slot trigger source decode and pending-set term
    genvar gi;
    generate
        for (gi = 0; gi < NSLOT; gi++) begin : g_slot
            logic [1:0] its;
            logic [4:0] tsel;
            logic [4:0] toff;
            logic       tvalid;
            assign its    = itrig_all[2*gi +: 2];
            assign tsel   = i_slot_config[gi][`ADCARB_TSEL_MSB:`ADCARB_TSEL_LSB];
            assign toff   = tsel - `ADCARB_TSEL_FIRST;
            assign tvalid = (tsel >= `ADCARB_TSEL_FIRST) && (tsel <= `ADCARB_TSEL_LAST);
            // One continuous driver per bit; a nonzero irq field overrides the start trigger
            assign slot_set[gi] = (its == `ADCARB_ITRIG_LINE1) ? r_r.irq[0]
                                : (its == `ADCARB_ITRIG_LINE2) ? r_r.irq[1]
                                : (its == `ADCARB_ITRIG_NONE)  ? (tvalid && link.pwm_trigger_input[toff])
                                : 1'b0;
            assign slot_bad[gi] = (its == 2'h3) || ((its == `ADCARB_ITRIG_NONE) && !tvalid);
        end
    endgenerate

    // Round-robin search upward from the pointer plus one
    always_comb begin
        adcarb_idx_t idx;
        idx       = 4'h0;
        grant_ok  = 1'b0;
        grant_idx = 4'h0;
        for (int k = 1; k <= NSLOT; k++) begin
            idx = r_r.ptr + k[3:0];
            if (!grant_ok && r_r.pend[idx]) begin
                grant_ok  = 1'b1;
                grant_idx = idx;
            end
        end
    end

    // End of conversion in this cycle
    assign finish = (r_r.st == ADCARB_CONVERT) && (r_r.cnt == 10'h000);

    // Interrupt source match per irq line
    generate
        for (gi = 0; gi < NIRQ; gi++) begin : g_irq
            adcarb_word_t pw;
            logic         en;
            adcarb_idx_t  src;
            assign pw  = i_irq_pair_sel[gi/2];
            assign en  = (gi % 2 == 0) ? pw[`ADCARB_EN1_BIT] : pw[`ADCARB_EN2_BIT];
            assign src = (gi % 2 == 0) ? pw[`ADCARB_SEL1_MSB:`ADCARB_SEL1_LSB]
                                       : pw[`ADCARB_SEL2_MSB:`ADCARB_SEL2_LSB];
            assign irq_fire[gi] = finish && en && (src == r_r.slot);
        end
    endgenerate

    // Next-state logic of the sequencer
    always_comb begin
        logic [3:0]  chan;
        logic [4:0]  h;
        logic [14:0] prod;
        logic [14:0] cyc;
        chan  = 4'h0;
        h     = 5'h00;
        prod  = 15'h0000;
        cyc   = 15'h0000;
        r_nxt = r_r;
        r_nxt.irq = irq_fire;
        r_nxt.err = |slot_bad;
        case (r_r.st)
            ADCARB_IDLE: begin
                if (grant_ok && i_ctl_one[`ADCARB_POWER_UP_BIT]) begin
                    r_nxt.st   = ADCARB_SAMPLE;
                    r_nxt.slot = grant_idx;
                    r_nxt.cnt  = {1'b0, i_slot_config[grant_idx][`ADCARB_WIN_MSB:`ADCARB_WIN_LSB]};
                    r_nxt.diff = i_input_mode_bit;
                    // Converter clock in half system clocks per converter clock
                    r_nxt.half = (i_prescale == 4'h0) ? 5'h02 : {1'b0, i_prescale} + 5'h02;
                end
            end
            ADCARB_SAMPLE: begin
                if (r_r.cnt == 10'h000) begin
                    chan = i_slot_config[r_r.slot][`ADCARB_CHAN_MSB:`ADCARB_CHAN_LSB];
                    if (r_r.diff) begin
                        // Pair chosen with bit zero ignored
                        r_nxt.sample = link.analog_input[{chan[3:1], 1'b0}]
                                     - link.analog_input[{chan[3:1], 1'b1}];
                    end else begin
                        r_nxt.sample = {4'h0, link.analog_input[chan][11:0]};
                    end
                    h    = r_r.half;
                    prod = (r_r.diff ? `ADCARB_DIFF_HALF : `ADCARB_SE_HALF) * h;
                    // Half-clock products round up to whole system clocks
                    cyc  = (prod + 15'h0003) >> 2;
                    r_nxt.cnt = cyc[9:0] - 10'h001;
                    r_nxt.st  = ADCARB_CONVERT;
                end else begin
                    r_nxt.cnt = r_r.cnt - 10'h001;
                end
            end
            ADCARB_CONVERT: begin
                if (finish) begin
                    r_nxt.res[r_r.slot] = r_r.sample;
                    r_nxt.ptr = r_r.slot;
                    r_nxt.st  = ADCARB_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt - 10'h001;
                end
            end
            default: begin
                r_nxt.st = ADCARB_IDLE;
            end
        endcase
        // Finished slot clears; a new trigger in the same cycle wins
        r_nxt.pend = (r_r.pend & ~(finish ? (16'h0001 << r_r.slot) : 16'h0000)) | slot_set;
        // Busy kept as its own flop so the output needs no decode
        r_nxt.busy = (r_nxt.st != ADCARB_IDLE);
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_r        <= '0;
            r_r.st     <= ADCARB_IDLE;
            r_r.ptr    <= `ADCARB_PTR_RST;
        end else begin
            r_r        <= r_nxt;
        end
    end

    // Outputs from state flops
    assign o_converter_busy      = r_r.busy;
    assign o_busy_slot_index     = r_r.slot;
    assign o_last_served_pointer = r_r.ptr;
    assign o_pending             = r_r.pend;
    assign o_config_error        = r_r.err;
    assign link.irq_line         = r_r.irq;

    // Result words per slot
    generate
        for (gi = 0; gi < NSLOT; gi++) begin : g_res
            assign o_slot_result[gi] = r_r.res[gi];
        end
    endgenerate
endmodule : adcarb_device

// ==== verilog/adcarb_host.sv ====
// Purpose: Trigger source and interrupt consumer end of the converter arbiter link
// Assumes: Same system clock as the device end
// Notes:   Fire strobes become one-cycle start triggers on the link
`timescale 1ns/10ps
`include "adcarb_defs.svh"
module adcarb_host (
    input  wire logic                      i_clk,        // System clock 200 MHz
    input  wire logic                      i_rstn,       // Async reset, active low
    adcarb_if.host                         link,         // Link to device end
    input  wire logic                      i_fire,       // Fire one start trigger
    input  wire logic [4:0]                i_fire_code,  // Trigger select code to fire
    input  wire adcarb_pkg::adcarb_word_t  i_sample [16], // Input sample words
    output logic [3:0]                     o_irq,        // Interrupt pulses seen
    output logic                           o_code_error  // Last fire code was invalid
);
    import adcarb_pkg::*;

    typedef struct packed {
        logic [NTRIG-1:0]         trig;
        adcarb_word_t [NSLOT-1:0] smp;
        logic [NIRQ-1:0]          irq;
        logic                     err;
    } adcarb_hstate_s;

    adcarb_hstate_s h_r;
    adcarb_hstate_s h_nxt;

    // Trigger code to trigger bit, ascending A/C then B/D pairs
    always_comb begin
        logic [4:0] off;
        logic       ok;
        off   = i_fire_code - `ADCARB_TSEL_FIRST;
        ok    = (i_fire_code >= `ADCARB_TSEL_FIRST) && (i_fire_code <= `ADCARB_TSEL_LAST);
        h_nxt = h_r;
        h_nxt.trig = '0;
        if (i_fire && ok) begin
            h_nxt.trig[off] = 1'b1;
        end
        if (i_fire) begin
            h_nxt.err = !ok;
        end
        for (int i = 0; i < NSLOT; i++) begin
            h_nxt.smp[i] = i_sample[i];
        end
        h_nxt.irq = link.irq_line;
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            h_r <= '0;
        end else begin
            h_r <= h_nxt;
        end
    end

    // Link and user outputs from flops
    assign link.pwm_trigger_input = h_r.trig;
    assign link.analog_input      = h_r.smp;
    assign o_irq                  = h_r.irq;
    assign o_code_error           = h_r.err;
endmodule : adcarb_host

// ==== test/adcarb_asserts.sv ====
// Purpose: Timing checks on the arbiter link and status outputs
// Assumes: One clock, async active-low reset
// Notes:   Watches design-driven signals only
`timescale 1ns/10ps
module adcarb_asserts (
    input wire logic                    i_clk,                 // System clock
    input wire logic                    i_rstn,                // Reset, active low
    input wire logic [23:0]             pwm_trigger_input,     // Start triggers
    input wire logic [3:0]              irq_line,              // Irq pulses
    input wire logic                    o_converter_busy,      // Busy flag
    input wire adcarb_pkg::adcarb_idx_t o_busy_slot_index,     // Granted slot
    input wire adcarb_pkg::adcarb_idx_t o_last_served_pointer, // Last served slot
    input wire logic [15:0]             o_pending              // Pending flags
);
    logic [3:0] rr_pick;
    // First pending slot after the pointer, wrapping
    always_comb begin
        rr_pick = o_last_served_pointer;
        for (int k = 16; k >= 1; k--) begin
            if (o_pending[4'(o_last_served_pointer + k)]) rr_pick = 4'(o_last_served_pointer + k);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_irq_pulse; |irq_line |=> irq_line == 4'h0; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one clock");
    property p_irq_finish; |irq_line |-> $fell(o_converter_busy); endproperty
    a_irq_finish: assert property (p_irq_finish) else $error("irq apart from result latch");
    property p_ptr_upd; $fell(o_converter_busy) |-> o_last_served_pointer == o_busy_slot_index; endproperty
    a_ptr_upd: assert property (p_ptr_upd) else $error("pointer not last slot");
    property p_ptr_rst; $rose(i_rstn) |-> o_last_served_pointer == 4'hF; endproperty
    a_ptr_rst: assert property (p_ptr_rst) else $error("pointer not 15 after reset");
    property p_grant_rr; $rose(o_converter_busy) |-> o_busy_slot_index == $past(rr_pick); endproperty
    a_grant_rr: assert property (p_grant_rr) else $error("grant out of round robin order");
    property p_busy_min; $rose(o_converter_busy) |-> o_converter_busy[*8] ##1 o_converter_busy[*4]; endproperty
    a_busy_min: assert property (p_busy_min) else $error("conversion too short");
    property p_pend_hold; !$fell(o_converter_busy) |-> ($past(o_pending) & ~o_pending) == 16'h0000; endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending lost outside finish");
    property p_trig_one; $onehot0(pwm_trigger_input); endproperty
    a_trig_one: assert property (p_trig_one) else $error("several start triggers at once");
endmodule : adcarb_asserts

// ==== test/tb_adc_conversion_arbiter_irq.sv ====
// Purpose: Self-checking bench with both link ends joined
// Assumes: Bench model tracks pending, pointer, timing and results
// Notes:   Random values from an LFSR with a fixed start
`timescale 1ns/10ps
module tb_adc_conversion_arbiter_irq;
    import adcarb_pkg::*;
    logic         i_clk = 0, i_rstn = 0, fire = 0, mode = 0, busy, cerr, herr;
    logic [4:0]   code = 5'h00;
    logic [4:0]   tcodes [6] = '{5'h04, 5'h05, 5'h1C, 5'h1D, 5'h00, 5'h1F};
    logic [3:0]   pres = 4'h0, bslot, ptr, hirq;
    logic [3:0]   ptab [4] = '{4'h0, 4'h2, 4'hF, 4'h3};
    logic [15:0]  pend, w;
    logic [31:0]  lf = 32'h3DE29C49, f;
    adcarb_cfg_t  cfg [16];
    adcarb_word_t ctl = 16'h0084, tlo = 16'h0000, thi = 16'h0000, psel [2], smp [16], res [16];
    int           bad_count = 0, tests_run = 0, mpend = 0, mptr = 15, cur = 0, cyc = 0, pb = 0, he = 0, s, n, e;
    adcarb_if lnk ();
    adcarb_device adcarb_device_inst (.i_clk(i_clk), .i_rstn(i_rstn), .link(lnk.device), .i_slot_config(cfg),
        .i_ctl_one(ctl), .i_irq_pair_sel(psel), .i_irq_trig_low(tlo), .i_irq_trig_high(thi),
        .i_input_mode_bit(mode), .i_prescale(pres), .o_converter_busy(busy), .o_busy_slot_index(bslot),
        .o_last_served_pointer(ptr), .o_pending(pend), .o_config_error(cerr), .o_slot_result(res));
    adcarb_host adcarb_host_inst (.i_clk(i_clk), .i_rstn(i_rstn), .link(lnk.host), .i_fire(fire),
        .i_fire_code(code), .i_sample(smp), .o_irq(hirq), .o_code_error(herr));
    adcarb_asserts adcarb_asserts_inst (.i_clk(i_clk), .i_rstn(i_rstn), .pwm_trigger_input(lnk.pwm_trigger_input),
        .irq_line(lnk.irq_line), .o_converter_busy(busy), .o_busy_slot_index(bslot),
        .o_last_served_pointer(ptr), .o_pending(pend));
    // Clock at 200 MHz
    always #2.5 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    function automatic int rr(int p, int m);
        for (int k = 1; k <= 16; k++) begin
            if (m[(p + k) % 16]) return (p + k) % 16;
        end
        return -1;
    endfunction : rr
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic fire_slot(int sl, logic err);
        f = {thi, tlo} >> (2 * sl);
        fire = 1;
        code = 5'(sl + 5);
        if (sl < 16 && f[1:0] == 2'h0) mpend |= 1 << sl;
        tick(1);
        fire = 0;
        tick(1);
        chk("host code error", herr, err);
    endtask : fire_slot
    task automatic wait_idle();
        for (int i = 0; i < 4000 && (mpend != 0 || busy !== 1'b0); i++) tick(1);
        chk("drained", mpend, 0);
    endtask : wait_idle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // Model: predicts each grant and checks each finished conversion
    always @(posedge i_clk) begin
        if (i_rstn === 1'b1) chk("host irq", hirq, he);
        he = 0;
        if (busy === 1'b1 && pb == 0) begin
            cur = rr(mptr, mpend);
            cyc = 0;
            chk("granted slot", bslot, cur);
        end
        if (busy === 1'b1) cyc++;
        if (busy === 1'b0 && pb == 1) begin
            n = ((mode ? 59 : 21) * (pres == 0 ? 2 : pres + 2) + 3) / 4;
            chk("busy cycles", cyc, cfg[cur][8:0] + 1 + n);
            s = cfg[cur][18:15];
            chk("slot result", res[cur], mode ? 16'(smp[s & 14] - smp[s | 1]) : {4'h0, smp[s][11:0]});
            chk("pointer", ptr, cur);
            chk("pending cleared", pend[cur], 0);
            e = 0;
            for (int j = 0; j < 4; j++) begin
                w = psel[j / 2] >> (j % 2 * 8);
                if (w[5] && w[3:0] == cur) e |= 1 << j;
            end
            chk("irq lines", lnk.irq_line, e);
            he = e;
            mpend &= ~(1 << cur);
            mptr = cur;
            for (int j = 0; j < 16; j++) begin
                f = {thi, tlo} >> (2 * j);
                if ((f[1:0] == 2'h1 && e[0]) || (f[1:0] == 2'h2 && e[1])) mpend |= 1 << j;
            end
        end
        pb = (busy === 1'b1);
    end
    // Main sequence
    initial begin
        for (int i = 0; i < 16; i++) begin
            cfg[i] = 32'((i + 5) << 20);
            smp[i] = 16'h0000;
        end
        psel = '{16'h4040, 16'h4040};
        tick(6);
        i_rstn = 1;
        tick(1);
        chk("pointer at reset", ptr, 15);
        chk("pending at reset", pend, 0);
        for (int i = 0; i < 6; i++) begin
            cfg[0][24:20] = tcodes[i];
            tick(3);
            chk("config error", cerr, tcodes[i] < 5 || tcodes[i] > 28);
        end
        cfg[0][24:20] = 5'h05;
        tlo = 16'h0003;
        tick(3);
        chk("config error field", cerr, 1);
        tlo = 16'h0000;
        fire_slot(24, 1);
        // A pending slot waits while the converter is powered down
        ctl = 16'h0004;
        fire_slot(3, 0);
        tick(20);
        chk("held pending", pend[3], 1);
        chk("held busy", busy, 0);
        ctl = 16'h0084;
        wait_idle();
        $display("test config errors done");
        for (int b = 0; b < 4; b++) begin
            mode = b[0];
            pres = ptab[b];
            for (int i = 0; i < 16; i++) begin
                lf = nxt(lf);
                cfg[i][8:0] = 9'(8 + lf[2:0]);
                cfg[i][18:15] = lf[7:4];
                smp[i] = lf[31:16];
            end
            lf = nxt(lf);
            psel = '{(lf[15:0] & 16'h2F2F) | 16'h4040, (lf[31:16] & 16'h2F2F) | 16'h4040};
            tick(2);
            fire_slot(lf[3:0], 0);
            tick(3);
            repeat (4) begin
                lf = nxt(lf);
                fire_slot(lf[3:0], 0);
            end
            wait_idle();
            $display("test batch %0d done", b);
        end
        tlo = 16'h0010;
        thi = 16'h0008;
        psel = '{16'h6260, 16'h4040};
        tick(2);
        fire_slot(2, 0);
        fire_slot(0, 0);
        wait_idle();
        $display("test internal triggers done");
        end_of_test();
    end
    // Run limit far above the longest expected sequence
    initial begin
        #400000;
        bad_count++;
        end_of_test();
    end
endmodule : tb_adc_conversion_arbiter_irq
